// *** hw/csrc_pkg.sv ***
package csrc_pkg;

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] OFS_PLL_MODE_CONTROL = 10'h010;
  localparam logic [ADDR_W-1:0] OFS_PREDIVIDER_RATIO_SELECT = 10'h1e0;
  localparam logic [ADDR_W-1:0] OFS_SOURCE_ROUTING_SELECT = 10'h1e1;
  localparam logic [ADDR_W-1:0] OFS_CONFIGURATION_UPDATE = 10'h232;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_PLL_MODE_CONTROL = 8'h01;
  localparam logic [DATA_W-1:0] RST_PREDIVIDER_RATIO_SELECT = 8'h02;
  localparam logic [DATA_W-1:0] RST_SOURCE_ROUTING_SELECT = 8'h00;
  localparam logic [DATA_W-1:0] RST_CONFIGURATION_UPDATE = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int PLL_MODE_LSB = 0;
  localparam int PLL_MODE_MSB = 1;
  localparam int PD_POLARITY_BIT = 7;
  localparam int PREDIV_LSB = 0;
  localparam int PREDIV_MSB = 2;
  localparam int ROUTE_BYPASS_BIT = 0;
  localparam int ROUTE_SOURCE_BIT = 1;
  localparam int UPDATE_PENDING_BIT = 1;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] PLL_MODE_NORMAL = 2'h0;
  localparam logic [1:0] PLL_MODE_ASYNC_PD = 2'h1;
  localparam logic [DATA_W-1:0] UPDATE_GO = 8'h01;
  localparam logic [2:0] PREDIV_BASE = 3'h2;
  localparam logic [2:0] PREDIV_MAX_CODE = 3'h4;
  localparam logic [2:0] PREDIV_MAX_RATIO = 3'h6;
  localparam logic [2:0] CNT_ONE = 3'h1;
  localparam logic [2:0] CNT_ZERO = 3'h0;

  typedef enum logic [1:0] {
    UPD_IDLE = 2'b00,
    UPD_XFER = 2'b01,
    UPD_DONE = 2'b10
  } csrc_upd_e;

endpackage : csrc_pkg

// *** hw/csrc_predivider.sv ***
`timescale 1ns/1ps

// Divides the sampled source by 2..6, or passes it straight through.
module csrc_predivider #(
  parameter int CNT_W = 3
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic src_level,
  input wire logic [CNT_W-1:0] div_ratio,
  input wire logic bypass,
  output logic div_out
);

  logic src_prev_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] half;
  logic src_rise;

  assign src_rise = src_level & ~src_prev_r;
  assign half = div_ratio >> 1;

  always_comb begin
    cnt_nxt = cnt_r;
    if (src_rise) begin
      if (cnt_r >= div_ratio - csrc_pkg::CNT_ONE) begin
        cnt_nxt = csrc_pkg::CNT_ZERO;
      end else begin
        cnt_nxt = cnt_r + csrc_pkg::CNT_ONE;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      src_prev_r <= 1'b0;
      cnt_r <= '0;
    end else begin
      src_prev_r <= src_level;
      cnt_r <= cnt_nxt;
    end
  end

  // Odd ratios give a high phase one source cycle shorter than the low phase
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      div_out <= 1'b0;
    end else if (bypass) begin
      div_out <= src_level;
    end else begin
      div_out <= (cnt_nxt < half);
    end
  end

endmodule : csrc_predivider

// *** hw/clock_source_routing_config.sv ***
`timescale 1ns/1ps

module clock_source_routing_config (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [csrc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [csrc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [csrc_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic ext_clk_in,
  input wire logic vco_clk_in,
  output logic [1:0] pll_power_mode,
  output logic pll_on,
  output logic pll_async_pd,
  output logic phase_detector_negative,
  output logic [2:0] predivider_ratio,
  output logic predivider_bypass,
  output logic source_internal_vco,
  output logic internal_vco_on,
  output logic prescaler_from_external,
  output logic dist_clk_out,
  output logic update_done
);

  // ----------------------------------------------------------------
  // Staged (software-visible) registers
  // ----------------------------------------------------------------
  logic [csrc_pkg::DATA_W-1:0] pll_mode_control_r;
  logic [csrc_pkg::DATA_W-1:0] predivider_ratio_select_r;
  logic [csrc_pkg::DATA_W-1:0] source_routing_select_r;
  logic [csrc_pkg::DATA_W-1:0] configuration_update_r;
  logic pending_r;

  // ----------------------------------------------------------------
  // Active copies that steer the hardware
  // ----------------------------------------------------------------
  logic [csrc_pkg::DATA_W-1:0] act_pll_mode_r;
  logic [csrc_pkg::DATA_W-1:0] act_prediv_r;
  logic [csrc_pkg::DATA_W-1:0] act_route_r;

  csrc_pkg::csrc_upd_e upd_state_r;
  csrc_pkg::csrc_upd_e upd_state_nxt;

  logic wr_mode;
  logic wr_prediv;
  logic wr_route;
  logic wr_update;
  logic update_go;
  logic [2:0] ratio_nxt;
  logic [2:0] act_code;
  logic src_level;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign wr_mode = reg_wr && (reg_addr == csrc_pkg::OFS_PLL_MODE_CONTROL);
  assign wr_prediv = reg_wr && (reg_addr == csrc_pkg::OFS_PREDIVIDER_RATIO_SELECT);
  assign wr_route = reg_wr && (reg_addr == csrc_pkg::OFS_SOURCE_ROUTING_SELECT);
  assign wr_update = reg_wr && (reg_addr == csrc_pkg::OFS_CONFIGURATION_UPDATE);
  assign update_go = wr_update && (reg_wdata == csrc_pkg::UPDATE_GO);

  // ----------------------------------------------------------------
  // Staged register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pll_mode_control_r <= csrc_pkg::RST_PLL_MODE_CONTROL;
    end else if (wr_mode) begin
      pll_mode_control_r <= reg_wdata;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      predivider_ratio_select_r <= csrc_pkg::RST_PREDIVIDER_RATIO_SELECT;
    end else if (wr_prediv) begin
      predivider_ratio_select_r <= reg_wdata;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      source_routing_select_r <= csrc_pkg::RST_SOURCE_ROUTING_SELECT;
    end else if (wr_route) begin
      source_routing_select_r <= reg_wdata;
    end
  end

  // Update register clears itself once the transfer has been made
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      configuration_update_r <= csrc_pkg::RST_CONFIGURATION_UPDATE;
    end else if (wr_update) begin
      configuration_update_r <= reg_wdata;
    end else if (upd_state_r == csrc_pkg::UPD_DONE) begin
      configuration_update_r <= csrc_pkg::RST_CONFIGURATION_UPDATE;
    end
  end

  // Pending marks staged writes not yet made active; a new write wins over the clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pending_r <= 1'b0;
    end else if (wr_mode || wr_prediv || wr_route) begin
      pending_r <= 1'b1;
    end else if (upd_state_r == csrc_pkg::UPD_XFER) begin
      pending_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Update sequencer
  // ----------------------------------------------------------------
  always_comb begin
    upd_state_nxt = upd_state_r;
    unique case (upd_state_r)
      csrc_pkg::UPD_IDLE: begin
        if (update_go) begin
          upd_state_nxt = csrc_pkg::UPD_XFER;
        end
      end
      csrc_pkg::UPD_XFER: begin
        upd_state_nxt = csrc_pkg::UPD_DONE;
      end
      csrc_pkg::UPD_DONE: begin
        upd_state_nxt = csrc_pkg::UPD_IDLE;
      end
      default: begin
        upd_state_nxt = csrc_pkg::UPD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      upd_state_r <= csrc_pkg::UPD_IDLE;
    end else begin
      upd_state_r <= upd_state_nxt;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      update_done <= 1'b0;
    end else begin
      update_done <= (upd_state_r == csrc_pkg::UPD_XFER);
    end
  end

  // ----------------------------------------------------------------
  // Active configuration
  // ----------------------------------------------------------------
  // Writes made while a transfer is in flight still land in the staged copy
  // and wait for the next update; the transfer samples in one cycle.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      act_pll_mode_r <= csrc_pkg::RST_PLL_MODE_CONTROL;
      act_prediv_r <= csrc_pkg::RST_PREDIVIDER_RATIO_SELECT;
      act_route_r <= csrc_pkg::RST_SOURCE_ROUTING_SELECT;
    end else if (upd_state_r == csrc_pkg::UPD_XFER) begin
      act_pll_mode_r <= pll_mode_control_r;
      act_prediv_r <= predivider_ratio_select_r;
      act_route_r <= source_routing_select_r;
    end
  end // Otherwise held regardless of staged writes

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  assign act_code = act_prediv_r[csrc_pkg::PREDIV_MSB:csrc_pkg::PREDIV_LSB];

  // Undefined codes above divide-by-6 clamp to the slowest ratio, which
  // keeps the channel dividers inside their limit if software slips
  always_comb begin
    if (act_code > csrc_pkg::PREDIV_MAX_CODE) begin
      ratio_nxt = csrc_pkg::PREDIV_MAX_RATIO;
    end else begin
      ratio_nxt = act_code + csrc_pkg::PREDIV_BASE;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pll_power_mode <= csrc_pkg::PLL_MODE_ASYNC_PD;
      pll_on <= 1'b0;
      pll_async_pd <= 1'b1;
    end else begin
      pll_power_mode <= act_pll_mode_r[csrc_pkg::PLL_MODE_MSB:csrc_pkg::PLL_MODE_LSB];
      pll_on <= (act_pll_mode_r[csrc_pkg::PLL_MODE_MSB:csrc_pkg::PLL_MODE_LSB]
                 == csrc_pkg::PLL_MODE_NORMAL);
      pll_async_pd <= (act_pll_mode_r[csrc_pkg::PLL_MODE_MSB:csrc_pkg::PLL_MODE_LSB]
                       == csrc_pkg::PLL_MODE_ASYNC_PD);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      phase_detector_negative <= 1'b0;
    end else begin
      phase_detector_negative <= act_pll_mode_r[csrc_pkg::PD_POLARITY_BIT];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      predivider_ratio <= csrc_pkg::PREDIV_BASE + csrc_pkg::RST_PREDIVIDER_RATIO_SELECT[2:0];
      predivider_bypass <= 1'b0;
      source_internal_vco <= 1'b0;
    end else begin
      predivider_ratio <= ratio_nxt;
      predivider_bypass <= act_route_r[csrc_pkg::ROUTE_BYPASS_BIT];
      source_internal_vco <= act_route_r[csrc_pkg::ROUTE_SOURCE_BIT];
    end
  end

  // Oscillator follows the active source only; prescaler feed follows the active mode and source
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      internal_vco_on <= 1'b0;
      prescaler_from_external <= 1'b0;
    end else begin
      internal_vco_on <= act_route_r[csrc_pkg::ROUTE_SOURCE_BIT];
      prescaler_from_external <= (act_pll_mode_r[csrc_pkg::PLL_MODE_MSB:csrc_pkg::PLL_MODE_LSB]
                                  == csrc_pkg::PLL_MODE_NORMAL)
                                 && !act_route_r[csrc_pkg::ROUTE_SOURCE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Distribution path
  // ----------------------------------------------------------------
  // Source levels are sampled on the system clock, so this path is a
  // behavioural stand-in valid only for sources well below clock/2.
  assign src_level = source_internal_vco ? vco_clk_in : ext_clk_in;

  csrc_predivider #(
    .CNT_W(3)
  ) u_prediv (
    .clock(clock),
    .rstn(rstn),
    .src_level(src_level),
    .div_ratio(predivider_ratio),
    .bypass(predivider_bypass),
    .div_out(dist_clk_out)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= csrc_pkg::READ_ZERO;
    end else if (reg_rd) begin
      unique case (reg_addr)
        csrc_pkg::OFS_PLL_MODE_CONTROL: reg_rdata <= pll_mode_control_r;
        csrc_pkg::OFS_PREDIVIDER_RATIO_SELECT: reg_rdata <= predivider_ratio_select_r;
        csrc_pkg::OFS_SOURCE_ROUTING_SELECT: reg_rdata <= source_routing_select_r;
        csrc_pkg::OFS_CONFIGURATION_UPDATE: begin
          reg_rdata <= configuration_update_r;
          reg_rdata[csrc_pkg::UPDATE_PENDING_BIT] <= pending_r;
        end
        default: reg_rdata <= csrc_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

endmodule : clock_source_routing_config

// *** test/csrc_asserts.sv ***
`timescale 1ns/1ps

// ------------------------------------------------------------
// Port-level checks
// ------------------------------------------------------------
module csrc_asserts (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [csrc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [csrc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_rvalid,
  input wire logic [1:0] pll_power_mode,
  input wire logic pll_on,
  input wire logic pll_async_pd,
  input wire logic [2:0] predivider_ratio,
  input wire logic predivider_bypass,
  input wire logic source_internal_vco,
  input wire logic internal_vco_on,
  input wire logic prescaler_from_external,
  input wire logic update_done
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  rd_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  rvalid_pulse_a: assert property (!reg_rd |=> !reg_rvalid) else $error("spurious read valid");
  upd_cause_a: assert property (update_done |-> $past(reg_wr && reg_addr == csrc_pkg::OFS_CONFIGURATION_UPDATE
    && reg_wdata == csrc_pkg::UPDATE_GO, 2)) else $error("update without go write");
  upd_pulse_a: assert property (update_done |=> !update_done) else $error("update done too long");
  // Active copy may only move on the edge after a transfer
  hold_cfg_a: assert property (!update_done |=> $stable({pll_power_mode, predivider_ratio,
    predivider_bypass, source_internal_vco})) else $error("active config moved without update");
  pll_on_a: assert property (pll_on == (pll_power_mode == csrc_pkg::PLL_MODE_NORMAL))
    else $error("pll on mismatch");
  async_pd_a: assert property (pll_async_pd == (pll_power_mode == csrc_pkg::PLL_MODE_ASYNC_PD))
    else $error("power-down mismatch");
  presc_src_a: assert property (prescaler_from_external == (pll_on && !source_internal_vco)
    && internal_vco_on == source_internal_vco) else $error("prescaler routing mismatch");
  ratio_range_a: assert property (predivider_ratio inside {[3'h2:3'h6]}) else $error("ratio out of range");
  reset_dflt_a: assert property ($rose(rstn) |-> pll_power_mode == 2'h1 && predivider_ratio == 3'h4
    && !predivider_bypass && !source_internal_vco) else $error("reset defaults wrong");
endmodule : csrc_asserts

bind clock_source_routing_config csrc_asserts u_chk (.clock, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rvalid, .pll_power_mode, .pll_on, .pll_async_pd, .predivider_ratio, .predivider_bypass,
  .source_internal_vco, .internal_vco_on, .prescaler_from_external, .update_done);

// *** test/clock_source_routing_config_tb.sv ***
`timescale 1ns/1ps

module clock_source_routing_config_tb;
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] div;
    logic [7:0] route;
    logic [2:0] ratio;
  } csrc_row_s;

  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [csrc_pkg::ADDR_W-1:0] reg_addr = '0;
  logic [csrc_pkg::DATA_W-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ext_clk_in = 1'b0;
  logic vco_clk_in = 1'b0;
  logic [7:0] reg_rdata;
  logic [1:0] pll_power_mode;
  logic [2:0] predivider_ratio;
  logic reg_rvalid, pll_on, pll_async_pd, phase_detector_negative, predivider_bypass;
  logic source_internal_vco, internal_vco_on, prescaler_from_external, dist_clk_out, update_done;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  int rise_c = 0;
  int per_m = 0;
  logic last_d = 1'b0;
  logic [7:0] prev;
  csrc_row_s r;
  // Codes 5..7 clamp to divide-by-6; no row asks for a ratio below two
  csrc_row_s rows [6] = '{'{8'h00, 8'h00, 8'h00, 3'h2}, '{8'h81, 8'h01, 8'h01, 3'h3},
    '{8'h00, 8'h03, 8'h02, 3'h5}, '{8'h80, 8'h04, 8'h03, 3'h6}, '{8'h02, 8'h07, 8'h00, 3'h6},
    '{8'h01, 8'h02, 8'h00, 3'h4}};

  always #50 clock = ~clock;

  clock_source_routing_config DUT (.clock, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reg_rvalid, .ext_clk_in, .vco_clk_in, .pll_power_mode, .pll_on, .pll_async_pd, .phase_detector_negative,
    .predivider_ratio, .predivider_bypass, .source_internal_vco, .internal_vco_on, .prescaler_from_external,
    .dist_clk_out, .update_done);

  // ------------------------------------------------------------
  // Source clocks and distribution period meter
  // ------------------------------------------------------------
  always @(posedge clock) begin
    cyc <= cyc + 1;
    ext_clk_in <= ~ext_clk_in;
    if (cyc[0]) begin
      vco_clk_in <= ~vco_clk_in;
    end
    last_d <= dist_clk_out;
    if (dist_clk_out && !last_d) begin
      per_m <= cyc - rise_c;
      rise_c <= cyc;
    end
  end

  function automatic logic [7:0] act();
    return {1'b0, pll_power_mode, predivider_ratio, predivider_bypass, source_internal_vco};
  endfunction : act

  function automatic logic [7:0] flg();
    return {3'h0, pll_on, pll_async_pd, phase_detector_negative, internal_vco_on, prescaler_from_external};
  endfunction : flg

  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk("rvalid", {7'h0, reg_rvalid}, 8'h01);
    chk("rdata", reg_rdata, e);
  endtask : rd

  task automatic dflt();
    chk("active", act(), {1'b0, csrc_pkg::PLL_MODE_ASYNC_PD, 3'h4, 2'h0});
    chk("flags", flg(), 8'h08);
  endtask : dflt

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  initial begin
    #400_000;
    error_cnt++;
    summarize();
  end

  initial begin
    repeat (10) @(posedge clock);
    dflt();
    rstn <= 1'b1;
    @(posedge clock);
    #1;
    dflt();
    rd(csrc_pkg::OFS_PLL_MODE_CONTROL, 8'h01);
    rd(csrc_pkg::OFS_PREDIVIDER_RATIO_SELECT, 8'h02);
    rd(csrc_pkg::OFS_SOURCE_ROUTING_SELECT, 8'h00);
    rd(csrc_pkg::OFS_CONFIGURATION_UPDATE, 8'h00);
    repeat (60) @(posedge clock);
    chk("period", per_m[7:0], 8'h08);
    wr(10'h3ff, 8'h5a);
    rd(10'h3ff, 8'h00);
    // Any value other than 0x01 must leave the active copy alone
    wr(csrc_pkg::OFS_SOURCE_ROUTING_SELECT, 8'h03);
    wr(csrc_pkg::OFS_CONFIGURATION_UPDATE, 8'h02);
    repeat (4) @(posedge clock);
    #1;
    dflt();
    prev = act();
    foreach (rows[i]) begin
      r = rows[i];
      wr(csrc_pkg::OFS_PLL_MODE_CONTROL, r.mode);
      wr(csrc_pkg::OFS_PREDIVIDER_RATIO_SELECT, r.div);
      wr(csrc_pkg::OFS_SOURCE_ROUTING_SELECT, r.route);
      rd(csrc_pkg::OFS_PLL_MODE_CONTROL, r.mode);
      rd(csrc_pkg::OFS_PREDIVIDER_RATIO_SELECT, r.div);
      // Staged writes still waiting show as the pending bit of the update register
      rd(csrc_pkg::OFS_CONFIGURATION_UPDATE, 8'h02);
      chk("held", act(), prev);
      wr(csrc_pkg::OFS_CONFIGURATION_UPDATE, csrc_pkg::UPDATE_GO);
      // The done pulse stands for the single cycle after the transfer edge
      @(posedge clock);
      #1;
      chk("update_done", {7'h0, update_done}, 8'h01);
      @(posedge clock);
      #1;
      prev = {1'b0, r.mode[1:0], r.ratio, r.route[0], r.route[1]};
      chk("active", act(), prev);
      chk("flags", flg(), {3'h0, r.mode[1:0] == 2'h0, r.mode[1:0] == 2'h1, r.mode[7], r.route[1],
        r.mode[1:0] == 2'h0 && !r.route[1]});
      rd(csrc_pkg::OFS_CONFIGURATION_UPDATE, 8'h00);
      repeat (60) @(posedge clock);
      chk("period", per_m[7:0], 8'((r.route[1] ? 4 : 2) * (r.route[0] ? 1 : r.ratio)));
    end
    // Reset in mid-run must bring the defaults back at once
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    dflt();
    @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    #1;
    dflt();
    rd(csrc_pkg::OFS_PREDIVIDER_RATIO_SELECT, 8'h02);
    summarize();
  end
endmodule : clock_source_routing_config_tb
